// ---- sbr_pkg.sv ----
// Shared constants for the secondary bus reset and slot reset block.
// Assumes a 200 MHz core clock and a 32-bit AXI4-Lite register bus.
package sbr_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int NUM_DS = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DLY_W  = 8;
  localparam int CNT_W  = 24;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int RST_MIN_NS    = 200000;
  localparam int RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_UNIT_CYC  = 200;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFS_BRIDGE_US  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_BRIDGE_DS0 = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_HOTPLUG    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_SLOT_DS0   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STRIDE     = 8'h04;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int SEC_RESET_BIT  = 6;
  localparam int PWR_OFF_BIT    = 10;
  localparam int MODE_BIT       = 0;
  localparam int OUT_EN_BIT     = 1;
  localparam int P2R_LSB        = 8;
  localparam int R2P_LSB        = 16;
  localparam int STS_STRIDE     = 8;
  localparam logic [DLY_W-1:0] P2R_RESET = 8'h01;
  localparam logic [DLY_W-1:0] R2P_RESET = 8'h01;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Reset output modes
  typedef enum logic {
    SBR_MODE_PWR_EN = 1'b0,
    SBR_MODE_PWR_GD = 1'b1
  } sbr_mode_t;

  // Slot power sequence, Gray coded along the usual path
  typedef enum logic [1:0] {
    SBR_SLOT_OFF      = 2'b00,
    SBR_SLOT_PWR_WAIT = 2'b01,
    SBR_SLOT_ON       = 2'b11,
    SBR_SLOT_RST_WAIT = 2'b10
  } sbr_slot_state_t;

endpackage

// ---- sbr_sync2.sv ----
// Two flip-flop synchroniser for pin levels.
// Assumes each bit is an independent, slowly changing level.
module sbr_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // sbr_sync2

// ---- sbr_slot_seq.sv ----
// Power and reset sequencer for one downstream slot.
// Assumes power_good is already synchronised and delays are in clock cycles.
module sbr_slot_seq (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  // Control
  input  wire logic                      mode_pwr_good,
  input  wire logic                      power_off,
  input  wire logic                      power_good,
  input  wire logic [sbr_pkg::CNT_W-1:0] power_to_reset_delay_cyc,
  input  wire logic [sbr_pkg::CNT_W-1:0] reset_to_power_delay_cyc,
  input  wire logic [sbr_pkg::CNT_W-1:0] min_rst_cyc,
  // Slot outputs
  output logic                           reset_n,
  output logic                           power_enable
);

  sbr_pkg::sbr_slot_state_t state;
  sbr_pkg::sbr_slot_state_t next_state;
  logic [sbr_pkg::CNT_W-1:0] dly_cnt;
  logic [sbr_pkg::CNT_W-1:0] min_cnt;
  logic                      min_done;
  logic                      pg_wait;

  assign min_done = (min_cnt >= min_rst_cyc);
  // Delay from power good is counted only once good is seen
  assign pg_wait  = mode_pwr_good && !power_good;

  always_comb
  begin
    next_state = state;
    case (state)
      sbr_pkg::SBR_SLOT_OFF:
        if (!power_off)
          next_state = sbr_pkg::SBR_SLOT_PWR_WAIT;
      sbr_pkg::SBR_SLOT_PWR_WAIT:
        if (power_off)
          next_state = sbr_pkg::SBR_SLOT_RST_WAIT;
        else if (!pg_wait && dly_cnt >= power_to_reset_delay_cyc && min_done)
          next_state = sbr_pkg::SBR_SLOT_ON;
      sbr_pkg::SBR_SLOT_ON:
        if (power_off)
          next_state = sbr_pkg::SBR_SLOT_RST_WAIT;
        else if (pg_wait)
          next_state = sbr_pkg::SBR_SLOT_PWR_WAIT;
      sbr_pkg::SBR_SLOT_RST_WAIT:
        if (dly_cnt >= reset_to_power_delay_cyc)
          next_state = sbr_pkg::SBR_SLOT_OFF;
      default:
        next_state = sbr_pkg::SBR_SLOT_OFF;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state <= sbr_pkg::SBR_SLOT_OFF;
    else
      state <= next_state;
  end

  // Outputs follow the next state so reset leads power enable off
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      reset_n      <= 1'b0;
      power_enable <= 1'b0;
    end
    else
    begin
      reset_n      <= (next_state == sbr_pkg::SBR_SLOT_ON);
      power_enable <= (next_state != sbr_pkg::SBR_SLOT_OFF);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || next_state != state || (state == sbr_pkg::SBR_SLOT_PWR_WAIT && pg_wait))
      dly_cnt <= '0;
    else if (dly_cnt != '1)
      dly_cnt <= dly_cnt + 1'b1;
  end

  // Width of every reset pulse, reset included, is held in hardware
  always_ff @(posedge sys_clk)
  begin
    if (rst || reset_n)
      min_cnt <= '0;
    else if (!min_done)
      min_cnt <= min_cnt + 1'b1;
  end

endmodule // sbr_slot_seq

// ---- sbr_top.sv ----
// Secondary bus reset sequencing and downstream slot reset outputs.
// Assumes link status comes from core-clock logic; slot pins are asynchronous.
// Registers are reached over an AXI4-Lite slave.
//
// Our own choices: the AXI4-Lite register port and the address map.

module sbr_top #(
  parameter int MIN_RST_CYC  = sbr_pkg::RST_MIN_CYC,
  parameter int DLY_UNIT_CYC = sbr_pkg::DLY_UNIT_CYC
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  // AXI4-Lite write address
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [sbr_pkg::ADDR_W-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  input  wire logic [sbr_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  // AXI4-Lite write response
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  output logic [1:0]                      s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  input  wire logic [sbr_pkg::ADDR_W-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic [sbr_pkg::DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  // Downstream link control
  input  wire logic [sbr_pkg::NUM_DS-1:0] ds_link_up,
  output logic [sbr_pkg::NUM_DS-1:0]      ds_hot_reset_tx,
  output logic [sbr_pkg::NUM_DS-1:0]      ds_flush_rx,
  output logic [sbr_pkg::NUM_DS-1:0]      ds_reg_init,
  output logic [sbr_pkg::NUM_DS-1:0]      ds_logic_reset,
  output logic [sbr_pkg::NUM_DS-1:0]      ds_unsupported_req,
  // Slot pins
  output logic [sbr_pkg::NUM_DS-1:0]      slot_reset_out_n,
  output logic [sbr_pkg::NUM_DS-1:0]      slot_reset_out_oe,
  input  wire logic [sbr_pkg::NUM_DS-1:0] slot_reset_in,
  output logic [sbr_pkg::NUM_DS-1:0]      slot_power_enable_out,
  input  wire logic [sbr_pkg::NUM_DS-1:0] slot_power_good_n
);

  localparam int N = sbr_pkg::NUM_DS;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [sbr_pkg::CNT_W-1:0] to_cycles(input logic [sbr_pkg::DLY_W-1:0] f);
    to_cycles = sbr_pkg::CNT_W'(f) * sbr_pkg::CNT_W'(DLY_UNIT_CYC);
  endfunction

  function automatic logic lane_of(input logic [3:0] strb, input int bitpos);
    lane_of = strb[bitpos / 8];
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  logic                               us_sec_reset;
  logic [N-1:0]                       ds_sec_reset;
  logic                               mode_sel;
  logic                               out_enable;
  logic [sbr_pkg::DLY_W-1:0]          p2r_delay;
  logic [sbr_pkg::DLY_W-1:0]          r2p_delay;
  logic [N-1:0]                       power_off;
  logic                               us_prev;
  logic [N-1:0]                       ds_prev;
  logic [N-1:0]                       pg_n_sync;
  logic [N-1:0]                       pin_sync;
  logic [N-1:0]                       seq_reset_n;
  logic [N-1:0]                       seq_power_en;
  logic                               aw_held;
  logic                               w_held;
  logic [sbr_pkg::ADDR_W-1:0]         aw_addr;
  logic [sbr_pkg::DATA_W-1:0]         w_data;
  logic [3:0]                         w_strb;
  logic                               do_write;
  logic                               wr_map;
  logic                               rd_map;
  logic [sbr_pkg::DATA_W-1:0]         rd_word;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  sbr_sync2 #(
    .W (2 * N)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({slot_reset_in, slot_power_good_n}),
    .sync_out ({pin_sync, pg_n_sync})
  );

  // ************************************************************
  // AXI4-Lite write path
  // ************************************************************
  // Address and data are taken in either order; one write at a time
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (do_write)
      aw_held <= 1'b0;
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (do_write)
      w_held <= 1'b0;
  end
  always_comb
  begin
    wr_map = (aw_addr == sbr_pkg::OFS_BRIDGE_US) || (aw_addr == sbr_pkg::OFS_HOTPLUG)
             || (aw_addr == sbr_pkg::OFS_STATUS);
    for (int i = 0; i < N; i++)
    begin
      if (aw_addr == sbr_pkg::OFS_BRIDGE_DS0 + sbr_pkg::ADDR_W'(i) * sbr_pkg::OFS_STRIDE)
        wr_map = 1'b1;
      if (aw_addr == sbr_pkg::OFS_SLOT_DS0 + sbr_pkg::ADDR_W'(i) * sbr_pkg::OFS_STRIDE)
        wr_map = 1'b1;
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= sbr_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_map ? sbr_pkg::RESP_OKAY : sbr_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ************************************************************
  // Bridge control registers
  // ************************************************************
  // The upstream bit stays writable throughout, since the upstream port keeps running
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      us_sec_reset <= 1'b0;
    else if (do_write && aw_addr == sbr_pkg::OFS_BRIDGE_US
             && lane_of(w_strb, sbr_pkg::SEC_RESET_BIT))
      us_sec_reset <= w_data[sbr_pkg::SEC_RESET_BIT];
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ds_sec_reset <= '0;
    else
      for (int i = 0; i < N; i++)
        if (us_sec_reset)
          ds_sec_reset[i] <= 1'b0;
        else if (do_write
                 && aw_addr == sbr_pkg::OFS_BRIDGE_DS0 + sbr_pkg::ADDR_W'(i) * sbr_pkg::OFS_STRIDE
                 && lane_of(w_strb, sbr_pkg::SEC_RESET_BIT))
          ds_sec_reset[i] <= w_data[sbr_pkg::SEC_RESET_BIT];
  end

  // ************************************************************
  // Hot-plug configuration and slot control
  // ************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      mode_sel   <= sbr_pkg::SBR_MODE_PWR_EN;
      out_enable <= 1'b0;
      p2r_delay  <= sbr_pkg::P2R_RESET;
      r2p_delay  <= sbr_pkg::R2P_RESET;
    end
    else if (do_write && aw_addr == sbr_pkg::OFS_HOTPLUG)
    begin
      if (lane_of(w_strb, sbr_pkg::MODE_BIT))
      begin
        mode_sel   <= w_data[sbr_pkg::MODE_BIT];
        out_enable <= w_data[sbr_pkg::OUT_EN_BIT];
      end
      if (lane_of(w_strb, sbr_pkg::P2R_LSB))
        p2r_delay <= w_data[sbr_pkg::P2R_LSB +: sbr_pkg::DLY_W];
      if (lane_of(w_strb, sbr_pkg::R2P_LSB))
        r2p_delay <= w_data[sbr_pkg::R2P_LSB +: sbr_pkg::DLY_W];
    end
  end
  // Slot power stays software owned so a bus reset does not drop slot power
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      power_off <= '1;
    else
      for (int i = 0; i < N; i++)
        if (do_write
            && aw_addr == sbr_pkg::OFS_SLOT_DS0 + sbr_pkg::ADDR_W'(i) * sbr_pkg::OFS_STRIDE
            && lane_of(w_strb, sbr_pkg::PWR_OFF_BIT))
          power_off[i] <= w_data[sbr_pkg::PWR_OFF_BIT];
  end

  // ************************************************************
  // Secondary bus reset sequencing
  // ************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      us_prev            <= 1'b0;
      ds_prev            <= '0;
      ds_hot_reset_tx    <= '0;
      ds_flush_rx        <= '0;
      ds_reg_init        <= '0;
      ds_logic_reset     <= '0;
      ds_unsupported_req <= '0;
    end
    else
    begin
      us_prev <= us_sec_reset;
      ds_prev <= ds_sec_reset;
      for (int i = 0; i < N; i++)
      begin
        // Only downstream outputs exist here; the upstream port is never touched
        ds_hot_reset_tx[i]    <= (us_sec_reset || ds_sec_reset[i]) && ds_link_up[i];
        ds_flush_rx[i]        <= (us_sec_reset && !us_prev)
                                 || (ds_sec_reset[i] && !ds_prev[i]);
        ds_reg_init[i]        <= us_sec_reset && !us_prev;
        ds_logic_reset[i]     <= us_sec_reset;
        ds_unsupported_req[i] <= ds_sec_reset[i];
      end
    end
  end

  // ************************************************************
  // Slot power and reset outputs
  // ************************************************************
  for (genvar g = 0; g < N; g++)
  begin : g_slot
    sbr_slot_seq u_seq (
      .sys_clk       (sys_clk),
      .rst           (rst),
      .mode_pwr_good (mode_sel == sbr_pkg::SBR_MODE_PWR_GD),
      .power_off     (power_off[g]),
      .power_good    (!pg_n_sync[g]),
      .power_to_reset_delay_cyc   (to_cycles(p2r_delay)),
      .reset_to_power_delay_cyc   (to_cycles(r2p_delay)),
      .min_rst_cyc   (sbr_pkg::CNT_W'(MIN_RST_CYC)),
      .reset_n       (seq_reset_n[g]),
      .power_enable  (seq_power_en[g])
    );
  end
  assign slot_reset_out_n      = seq_reset_n;
  assign slot_reset_out_oe     = {N{out_enable}};
  assign slot_power_enable_out = seq_power_en;

  // ************************************************************
  // AXI4-Lite read path
  // ************************************************************
  always_comb
  begin
    rd_word = '0;
    rd_map  = 1'b1;
    if (s_axi_araddr == sbr_pkg::OFS_BRIDGE_US)
      rd_word[sbr_pkg::SEC_RESET_BIT] = us_sec_reset;
    else if (s_axi_araddr == sbr_pkg::OFS_HOTPLUG)
    begin
      rd_word[sbr_pkg::MODE_BIT]                    = mode_sel;
      rd_word[sbr_pkg::OUT_EN_BIT]                  = out_enable;
      rd_word[sbr_pkg::P2R_LSB +: sbr_pkg::DLY_W]   = p2r_delay;
      rd_word[sbr_pkg::R2P_LSB +: sbr_pkg::DLY_W]   = r2p_delay;
    end
    else if (s_axi_araddr == sbr_pkg::OFS_STATUS)
    begin
      for (int i = 0; i < N; i++)
        rd_word[i * sbr_pkg::STS_STRIDE +: 6] = {pin_sync[i], ds_sec_reset[i], !pg_n_sync[i],
                                                 seq_power_en[i], !seq_reset_n[i], ds_link_up[i]};
    end
    else
      rd_map = 1'b0;
    for (int i = 0; i < N; i++)
    begin
      if (s_axi_araddr == sbr_pkg::OFS_BRIDGE_DS0 + sbr_pkg::ADDR_W'(i) * sbr_pkg::OFS_STRIDE)
      begin
        rd_map                          = 1'b1;
        rd_word[sbr_pkg::SEC_RESET_BIT] = ds_sec_reset[i];
      end
      if (s_axi_araddr == sbr_pkg::OFS_SLOT_DS0 + sbr_pkg::ADDR_W'(i) * sbr_pkg::OFS_STRIDE)
      begin
        rd_map                        = 1'b1;
        rd_word[sbr_pkg::PWR_OFF_BIT] = power_off[i];
      end
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= sbr_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_map ? sbr_pkg::RESP_OKAY : sbr_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // sbr_top

// ---- sbr_monitor.sv ----
// Concurrent checks on the bus reset and slot reset outputs.
// Assumes it is bound to sbr_top and sees only that module's ports.
module sbr_monitor #(
  parameter int MIN_RST_CYC = 20
) (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // Link side
  input wire logic [1:0] ds_link_up,
  input wire logic [1:0] ds_hot_reset_tx,
  input wire logic [1:0] ds_flush_rx,
  input wire logic [1:0] ds_reg_init,
  input wire logic [1:0] ds_logic_reset,
  // Slot pins
  input wire logic [1:0] slot_reset_out_n,
  input wire logic [1:0] slot_reset_out_oe,
  input wire logic [1:0] slot_power_enable_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int low_cyc;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Saturates, so a long hold costs no width
  always_ff @(posedge sys_clk)
    if (rst || slot_reset_out_n[0]) low_cyc <= 0;
    else if (low_cyc < MIN_RST_CYC) low_cyc <= low_cyc + 1;
  hot_link_a: assert property (
    (ds_hot_reset_tx & ~$past(ds_link_up)) == 2'h0) else $error("Hot reset without link");
  logic_same_a: assert property (
    ds_logic_reset[0] == ds_logic_reset[1]) else $error("Port logic resets differ");
  init_flush_a: assert property (
    |ds_reg_init |-> ds_flush_rx == 2'h3) else $error("Init without full flush");
  init_pulse_a: assert property (
    ds_reg_init[0] |=> !ds_reg_init[0]) else $error("Init pulse too long");
  min_pulse_a: assert property (
    $rose(slot_reset_out_n[0]) |-> low_cyc >= MIN_RST_CYC - 1) else $error("Reset pulse short");
  rst_first_a: assert property (
    $fell(slot_power_enable_out[0]) |-> !slot_reset_out_n[0] && !$past(slot_reset_out_n[0]))
    else $error("Power dropped before reset");
  pwr_first_a: assert property (
    $rose(slot_reset_out_n[0]) |-> slot_power_enable_out[0] && $past(slot_power_enable_out[0]))
    else $error("Reset released without power");
  oe_reset_a: assert property (
    $fell(rst) |-> slot_reset_out_oe == 2'h0 && slot_power_enable_out == 2'h0)
    else $error("Slot pins driven after reset");
endmodule // sbr_monitor

// ---- sbr_slot_model.sv ----
// Two downstream slots: power switches, power good and reset pin pull-downs.
// Assumes power enable and reset pins come from the block under test.
module sbr_slot_model #(
  parameter int PG_DLY = 8
) (
  // Clock
  input wire logic       sys_clk,
  // From the block
  input wire logic [1:0] power_enable,
  input wire logic [1:0] reset_n,
  input wire logic [1:0] reset_oe,
  // Fault injection
  input wire logic [1:0] fault,
  // To the block
  output logic     [1:0] power_good_n,
  output logic     [1:0] reset_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int ramp [2];
  // Pull-down holds an undriven reset pin low
  assign reset_pin = reset_n & reset_oe;
  // Supply ramps for a while before good is reported
  always_ff @(posedge sys_clk)
    for (int i = 0; i < 2; i++)
      ramp[i] <= !power_enable[i] ? 0 : (ramp[i] < PG_DLY ? ramp[i] + 1 : ramp[i]);
  always_comb
    for (int i = 0; i < 2; i++)
      power_good_n[i] = !(power_enable[i] && ramp[i] >= PG_DLY && !fault[i]);
endmodule // sbr_slot_model

// ---- sbr_top_tb.sv ----
// Self-checking bench for sbr_top with the slot model on its pins.
// Assumes short minimum pulse and unit delay parameters for a quick run.
module sbr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MIN_RST = 20;
  localparam int PG_DLY  = 8;
  logic        sys_clk = 1'b0, rst = 1'b1;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ds_link_up, ds_hot_reset_tx, ds_flush_rx, ds_reg_init;
  logic [1:0]  ds_logic_reset, ds_unsupported_req, slot_reset_out_n, slot_reset_out_oe;
  logic [1:0]  slot_reset_in, slot_power_enable_out, slot_power_good_n, fault;
  logic [3:0]  seen_fl;
  int          failures = 0, checks_done = 0;
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) seen_fl <= seen_fl | {ds_reg_init, ds_flush_rx};
  sbr_top #(.MIN_RST_CYC(MIN_RST), .DLY_UNIT_CYC(1)) u_dut (.sys_clk, .rst,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .ds_link_up, .ds_hot_reset_tx, .ds_flush_rx, .ds_reg_init,
    .ds_logic_reset, .ds_unsupported_req, .slot_reset_out_n, .slot_reset_out_oe,
    .slot_reset_in, .slot_power_enable_out, .slot_power_good_n);
  sbr_slot_model #(.PG_DLY(PG_DLY)) u_slot (.sys_clk, .power_enable(slot_power_enable_out),
    .reset_n(slot_reset_out_n), .reset_oe(slot_reset_out_oe), .fault,
    .power_good_n(slot_power_good_n), .reset_pin(slot_reset_in));
  task complete_run();
    $display("Checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task tmo(input int n);
    if (n >= 200)
    begin
      failures++;
      complete_run();
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    bit aw, w;
    {n, aw, w} = '0;
    @(posedge sys_clk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    while (!(aw && w) && n < 200)
    begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) aw = 1;
      if (s_axi_wvalid && s_axi_wready) w = 1;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && n < 200)
    begin
      @(posedge sys_clk);
      n++;
    end
    tmo(n);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, 2'h0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk);
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    s_axi_araddr <= a;
    do @(posedge sys_clk); while (!s_axi_arready && ++n < 200);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid && ++n < 200);
    tmo(n);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, er);
  endtask
  // Waits for a slot reset (pe=0) or power enable (pe=1) level, counting edges
  task wt(input bit pe, input int i, input logic v, output int n);
    n = 0;
    do @(posedge sys_clk); while ((pe ? slot_power_enable_out[i] : slot_reset_out_n[i]) !== v
                                  && ++n < 200);
    tmo(n);
  endtask
  task t_reset();
    chk(slot_reset_out_oe, 2'h0);
    chk(slot_reset_in, 2'h0);
    rd(8'h0C, 32'h0001_0100, 2'h0);
    rd(8'h10, 32'h0000_0400, 2'h0);
    rd(8'h1C, 32'h0, 2'h2);
    rd(8'h18, 32'h0000_0202, 2'h0);
  endtask
  task t_us_reset();
    ds_link_up <= 2'h1;
    @(negedge sys_clk) seen_fl = 4'h0;
    wr(8'h00, 32'h40);
    repeat (2) @(posedge sys_clk);
    chk(ds_hot_reset_tx, 2'h1);
    chk(ds_logic_reset, 2'h3);
    chk(seen_fl, 4'hF);
    wr(8'h04, 32'h40);
    rd(8'h04, 32'h0, 2'h0);
    rd(8'h00, 32'h40, 2'h0);
    wr(8'h00, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk(ds_logic_reset, 2'h0);
  endtask
  task t_ds_reset();
    ds_link_up <= 2'h3;
    @(negedge sys_clk) seen_fl = 4'h0;
    wr(8'h08, 32'h40);
    repeat (2) @(posedge sys_clk);
    chk(ds_hot_reset_tx, 2'h2);
    chk(seen_fl, 4'h2);
    chk(ds_unsupported_req, 2'h2);
    chk(ds_logic_reset, 2'h0);
    rd(8'h08, 32'h40, 2'h0);
    wr(8'h08, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk(ds_unsupported_req, 2'h0);
  endtask
  task t_pwr_en();
    int n;
    wr(8'h0C, 32'h0003_0302);
    wr(8'h10, 32'h0);
    wt(1, 0, 1'b1, n);
    wt(0, 0, 1'b1, n);
    chk(n >= 3 && n <= 8, 1'b1);
    chk(slot_reset_in, 2'h1);
    wr(8'h10, 32'h400);
    wt(0, 0, 1'b0, n);
    chk(slot_power_enable_out[0], 1'b1);
    wt(1, 0, 1'b0, n);
    chk(n >= 2 && n <= 8, 1'b1);
  endtask
  task t_pwr_good();
    int n;
    wr(8'h0C, 32'h0003_0303);
    wr(8'h14, 32'h0);
    wt(1, 1, 1'b1, n);
    wt(0, 1, 1'b1, n);
    chk(n >= PG_DLY + 3 && n <= PG_DLY + 12, 1'b1);
    fault <= 2'h2;
    wt(0, 1, 1'b0, n);
    chk(n <= 6, 1'b1);
    fault <= 2'h0;
    wt(0, 1, 1'b1, n);
    chk(n >= MIN_RST - 1, 1'b1);
  endtask
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {ds_link_up, fault, seen_fl} = '0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_us_reset();
    t_ds_reset();
    t_pwr_en();
    t_pwr_good();
    complete_run();
  end
endmodule // sbr_top_tb
bind sbr_top sbr_monitor #(.MIN_RST_CYC(MIN_RST_CYC)) u_mon (.sys_clk, .rst, .ds_link_up,
  .ds_hot_reset_tx, .ds_flush_rx, .ds_reg_init, .ds_logic_reset, .slot_reset_out_n,
  .slot_reset_out_oe, .slot_power_enable_out);
